// *** design/ipst_clk_map.sv ***
// maps a 3-bit timing code onto a count of clocks
module ipst_clk_map (
  input wire logic [2:0] code,
  output logic [3:0] clocks
);
  // table: 1, 2, 3, 4, 8, 9, 10, 12
  always_comb begin
    unique case (code)
      3'h0: clocks = 4'h1;
      3'h1: clocks = 4'h2;
      3'h2: clocks = 4'h3;
      3'h3: clocks = 4'h4;
      3'h4: clocks = 4'h8;
      3'h5: clocks = 4'h9;
      3'h6: clocks = 4'hA;
      3'h7: clocks = 4'hC;
    endcase
  end
endmodule

// *** design/ipst_sync.sv ***
// three-stage synchroniser; change accepted when last two stages agree
module ipst_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);
  logic s1_q; // first stage, read only by s2
  logic s2_q;
  logic s3_q;
  // shift chain, resets to the idle-high level of a ready line
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule

// *** design/ipst_timing.sv ***
// programmed-transfer strobe timer with two channel timing registers
`include "ipst_defs.svh"
module ipst_timing (
  input wire logic clk,
  input wire logic reset_n,
  // configuration space access, one word per register
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  output logic [31:0] cfg_rdata,
  // host-side drive access request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_secondary,
  input wire logic [2:0] req_index,
  input wire logic [15:0] req_wdata,
  output logic done,
  output logic [15:0] rd_data,
  // drive-select state per channel
  input wire logic pri_slave_sel,
  input wire logic sec_slave_sel,
  // prefetch permission for the current command on each channel
  output logic pri_prefetch_en,
  output logic sec_prefetch_en,
  // drive pins
  output logic [2:0] drv_addr,
  output logic drv_cs_sec,
  output logic drv_rd_n,
  output logic drv_wr_n,
  input wire logic [15:0] drv_data_in,
  output logic [15:0] drv_data_out,
  output logic drv_data_oe,
  input wire logic drv_ready
);
  logic [31:0] pri_timing_q; // primary channel timing
  logic [31:0] sec_timing_q; // secondary channel timing
  logic pri_atapi_q; // packet command in flight, primary
  logic sec_atapi_q; // packet command in flight, secondary
  ipst_pkg::ipst_state_t state_q;
  logic [3:0] cnt_q; // clocks left in current phase
  logic [3:0] act_len_q; // latched active length
  logic [3:0] rec_len_q; // latched recovery length
  logic rdy_en_q; // latched ready sampling enable
  logic write_q; // current cycle is a write
  logic posted_q; // write already acknowledged
  logic [15:0] half; // selected timing half
  logic is_data; // access targets the data register
  logic [3:0] map_act;
  logic [3:0] map_rec;
  logic [3:0] setup_len;
  logic ready_s; // synchronised drive ready
  logic [31:0] wmask; // byte-enable and reserved-bit mask
  logic [31:0] rd_mask; // bits that exist and read back
  logic start;
  logic post_now;
  logic act_end;

  // ready crosses in from the pin; the three flops cost about four
  // clocks, so a drive must pull ready low early in the strobe
  ipst_sync u_rdy_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din(drv_ready),
    .dout(ready_s)
  );

  // mask of writable bits in both halves
  always_comb begin
    wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}},
      {8{cfg_be[0]}}};
    wmask = wmask & {`IPST_HALF_MASK, `IPST_HALF_MASK};
  end

  // reserved positions never reach the read port, whatever they hold
  assign rd_mask = {`IPST_HALF_MASK, `IPST_HALF_MASK};

  // timing register writes; only documented bits ever change after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pri_timing_q <= `IPST_TIMING_RESET;
      sec_timing_q <= `IPST_TIMING_RESET;
    end else if (cfg_wr) begin
      if (cfg_addr == `IPST_PRI_OFFSET) begin
        pri_timing_q <= (pri_timing_q & ~wmask) | (cfg_wdata & wmask);
      end
      if (cfg_addr == `IPST_SEC_OFFSET) begin
        sec_timing_q <= (sec_timing_q & ~wmask) | (cfg_wdata & wmask);
      end
    end
  end

  // read data, registered; unmapped offsets read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 32'h00000000;
    end else if (cfg_rd) begin
      if (cfg_addr == `IPST_PRI_OFFSET) begin
        cfg_rdata <= pri_timing_q & rd_mask;
      end else if (cfg_addr == `IPST_SEC_OFFSET) begin
        cfg_rdata <= sec_timing_q & rd_mask;
      end else begin
        cfg_rdata <= 32'h00000000;
      end
    end
  end

  // channel register, then drive half, for this request
  always_comb begin
    if (req_secondary) begin
      // upper half slave, lower half master
      half = sec_slave_sel ? sec_timing_q[31:16]
        : sec_timing_q[15:0];
    end else begin
      half = pri_slave_sel ? pri_timing_q[31:16]
        : pri_timing_q[15:0];
    end
  end

  // index zero is the data register; all else runs fixed active and recovery timing
  assign is_data = (req_index == `IPST_DATA_INDEX);

  // active and recovery lengths for the selected half
  ipst_clk_map u_act_map (
    .code(half[`IPST_ACT_HI:`IPST_ACT_LO]),
    .clocks(map_act)
  );

  ipst_clk_map u_rec_map (
    .code(half[`IPST_REC_HI:`IPST_REC_LO]),
    .clocks(map_rec)
  );

  // setup from the upper two active bits: 00->1, 01->2, 1x->3
  always_comb begin
    unique case (half[`IPST_SETUP_HI:`IPST_SETUP_LO])
      2'b00: setup_len = 4'h1;
      2'b01: setup_len = 4'h2;
      2'b10, 2'b11: setup_len = 4'h3;
    endcase
  end

  // one request at a time; the sequencer is the only resource
  assign req_ready = (state_q == ipst_pkg::IPST_IDLE);
  assign start = req_valid && req_ready;
  // only data-register writes may be posted
  assign post_now = start && req_write && is_data
    && half[`IPST_POST_BIT];
  // active ends at count one unless ready sampling is on and the drive holds ready low
  assign act_end = (cnt_q == 4'h1) && !(rdy_en_q && !ready_s);

  // strobe sequencer: setup, active, recovery
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ipst_pkg::IPST_IDLE;
      cnt_q <= 4'h0;
      act_len_q <= 4'h1;
      rec_len_q <= 4'h1;
      rdy_en_q <= 1'b0;
      write_q <= 1'b0;
      posted_q <= 1'b0;
    end else begin
      unique case (state_q)
        ipst_pkg::IPST_IDLE: begin
          if (start) begin
            state_q <= ipst_pkg::IPST_SETUP;
            cnt_q <= setup_len;
            // lengths latched here so a register write mid-cycle
            // cannot change a strobe already under way
            // non-data registers run on fixed ten-clock active and recovery; setup still follows the half
            act_len_q <= is_data ? map_act : `IPST_NONDATA_CLKS;
            rec_len_q <= is_data ? map_rec : `IPST_NONDATA_CLKS;
            rdy_en_q <= half[`IPST_RDY_BIT];
            write_q <= req_write;
            posted_q <= post_now;
          end
        end
        ipst_pkg::IPST_SETUP: begin
          // address and chip select already stand; wait out setup
          if (cnt_q == 4'h1) begin
            state_q <= ipst_pkg::IPST_ACTIVE;
            cnt_q <= act_len_q;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ipst_pkg::IPST_ACTIVE: begin
          // count holds at one while the drive stretches the strobe
          if (act_end) begin
            state_q <= ipst_pkg::IPST_RECOVER;
            cnt_q <= rec_len_q;
          end else if (cnt_q != 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ipst_pkg::IPST_RECOVER: begin
          // strobe inactive; next request refused until idle
          if (cnt_q == 4'h1) begin
            state_q <= ipst_pkg::IPST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  // address, data and strobes held from flip-flops for the cycle
  // write data enable drops only once idle, so the drive never sees
  // the bus released under a live write strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drv_addr <= 3'h0;
      drv_cs_sec <= 1'b0;
      drv_data_out <= 16'h0000;
      drv_data_oe <= 1'b0;
      drv_rd_n <= 1'b1;
      drv_wr_n <= 1'b1;
    end else begin
      if (start) begin
        drv_addr <= req_index;
        drv_cs_sec <= req_secondary;
        drv_data_out <= req_wdata;
        drv_data_oe <= req_write;
      end else if (state_q == ipst_pkg::IPST_IDLE) begin
        drv_data_oe <= 1'b0;
      end
      // strobe low exactly while the sequencer sits in the active state
      if (state_q == ipst_pkg::IPST_SETUP && cnt_q == 4'h1) begin
        drv_rd_n <= write_q;
        drv_wr_n <= !write_q;
      end else if (state_q == ipst_pkg::IPST_ACTIVE && act_end) begin
        drv_rd_n <= 1'b1;
        drv_wr_n <= 1'b1;
      end
    end
  end

  // completion pulse: posted writes at once, others at strobe end
  // a posted write answers the host early; the drive cycle still runs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      done <= post_now
        || (state_q == ipst_pkg::IPST_ACTIVE && act_end && !posted_q);
      if (state_q == ipst_pkg::IPST_ACTIVE && act_end && !write_q) begin
        rd_data <= drv_data_in;
      end
    end
  end

  // packet command tracking per channel; any other command clears it
  // flag lives until the next command write on the same channel
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pri_atapi_q <= 1'b0;
      sec_atapi_q <= 1'b0;
    end else if (start && req_write && req_index == `IPST_CMD_INDEX) begin
      if (req_secondary) begin
        sec_atapi_q <= (req_wdata[7:0] == `IPST_ATAPI_CMD);
      end else begin
        pri_atapi_q <= (req_wdata[7:0] == `IPST_ATAPI_CMD);
      end
    end
  end

  // prefetch permission: 0x off, 10 non-packet only, 11 always
  // trade-off: the half follows the live drive select, not one latched
  // per command, so software must not swap drives mid-command
  always_comb begin
    logic [15:0] ph;
    logic [15:0] sh;
    ph = pri_slave_sel ? pri_timing_q[31:16] : pri_timing_q[15:0];
    sh = sec_slave_sel ? sec_timing_q[31:16] : sec_timing_q[15:0];
    pri_prefetch_en = ph[`IPST_PREF_BIT]
      && (ph[`IPST_ATAPI_BIT] || !pri_atapi_q);
    sec_prefetch_en = sh[`IPST_PREF_BIT]
      && (sh[`IPST_ATAPI_BIT] || !sec_atapi_q);
  end
endmodule

// *** include/ipst_defs.svh ***
// offsets, field positions, reset values and timing counts for the strobe timer
`ifndef IPST_DEFS_SVH
`define IPST_DEFS_SVH

// configuration offsets of the two timing registers
`define IPST_PRI_OFFSET 8'h40
`define IPST_SEC_OFFSET 8'h44
// reset pattern of both timing registers
`define IPST_TIMING_RESET 32'h97609760
// writable bits of each 16-bit half; the rest read as zero
`define IPST_HALF_MASK 16'h03FF
// field positions inside one 16-bit half
`define IPST_REC_HI 9
`define IPST_REC_LO 7
`define IPST_ACT_HI 6
`define IPST_ACT_LO 4
`define IPST_SETUP_HI 6
`define IPST_SETUP_LO 5
`define IPST_RDY_BIT 3
`define IPST_POST_BIT 2
`define IPST_PREF_BIT 1
`define IPST_ATAPI_BIT 0
// fixed non-data timing, in clocks
`define IPST_NONDATA_CLKS 4'hA
// drive command register index and the packet command code
`define IPST_CMD_INDEX 3'h7
`define IPST_ATAPI_CMD 8'hA0
// drive data register index
`define IPST_DATA_INDEX 3'h0

`endif

// *** include/ipst_pkg.sv ***
// types shared by the strobe timing block
package ipst_pkg;
  // strobe sequencer states, gray coded along setup-active-recovery
  typedef enum logic [1:0] {
    IPST_IDLE = 2'b00,
    IPST_SETUP = 2'b01,
    IPST_ACTIVE = 2'b11,
    IPST_RECOVER = 2'b10
  } ipst_state_t;
endpackage

// *** test/ipst_drive_model.sv ***
// drive model: one word per register index, ready pulled low by stall
module ipst_drive_model (
  input wire logic clk,
  input wire logic [2:0] drv_addr,
  input wire logic drv_rd_n,
  input wire logic drv_wr_n,
  input wire logic [15:0] drv_data_out,
  input wire logic drv_data_oe,
  input wire logic stall,
  output logic [15:0] drv_data_in,
  output logic drv_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [8]; // drive register file
  logic [15:0] last_q = 16'h0000; // last word shown, inverted once released
  initial for (int i = 0; i < 8; i++) mem[i] = 16'h5A00 + 16'(i);
  // released bus shows inverse so stale data never looks valid
  assign drv_data_in = !drv_rd_n ? mem[drv_addr] : ~last_q;
  assign drv_ready = ~stall;
  // capture writes and remember what was shown
  always @(posedge clk) begin
    if (!drv_wr_n && drv_data_oe) mem[drv_addr] <= drv_data_out;
    if (!drv_rd_n) last_q <= mem[drv_addr];
  end
endmodule

// *** test/ipst_timing_props.sv ***
// assertion checker watching the strobe timer ports
module ipst_timing_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_secondary,
  input wire logic [2:0] req_index,
  input wire logic done,
  input wire logic [2:0] drv_addr,
  input wire logic drv_cs_sec,
  input wire logic drv_rd_n,
  input wire logic drv_wr_n,
  input wire logic drv_data_oe,
  input wire logic drv_ready
);
  logic strb_n; // high while neither strobe is driven
  logic nd; // cycle targets a control register, not data
  logic take; // request accepted this edge
  assign strb_n = drv_rd_n & drv_wr_n;
  assign nd = drv_addr != 3'h0;
  assign take = req_valid & req_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_setup_first: assert property (take |=> strb_n)
    else $error("strobe without address setup");
  // control reads assume ready high, otherwise stretching is legal
  a_ctrl_active: assert property (
    $fell(drv_rd_n) && nd && drv_ready |-> ##9 !drv_rd_n ##1 drv_rd_n)
    else $error("control active time wrong");
  a_ctrl_recover: assert property (
    $rose(strb_n) && nd |-> ##9 !req_ready ##1 req_ready)
    else $error("control recovery time wrong");
  a_read_done: assert property ($rose(drv_rd_n) |-> done)
    else $error("read done missing");
  a_ctrl_unposted: assert property ($rose(drv_wr_n) && nd |-> done)
    else $error("control write was posted");
  a_port_pick: assert property (
    take |=> drv_cs_sec == $past(req_secondary))
    else $error("wrong port selected");
  a_reg_index: assert property (take |=> drv_addr == $past(req_index))
    else $error("drive index wrong");
  a_unmapped_zero: assert property (
    cfg_rd && cfg_addr != 8'h40 && cfg_addr != 8'h44 |=> cfg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_write_drive: assert property (!drv_wr_n |-> drv_data_oe)
    else $error("write strobe without data");
  c_read: cover property ($rose(drv_rd_n));
  c_stretch: cover property (!drv_rd_n && !drv_ready);
  c_post: cover property (take ##1 done);
endmodule
bind ipst_timing ipst_timing_props u_props (.clk(clk), .reset_n(reset_n),
  .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
  .req_valid(req_valid), .req_ready(req_ready),
  .req_secondary(req_secondary), .req_index(req_index), .done(done),
  .drv_addr(drv_addr), .drv_cs_sec(drv_cs_sec), .drv_rd_n(drv_rd_n),
  .drv_wr_n(drv_wr_n), .drv_data_oe(drv_data_oe), .drv_ready(drv_ready));

// *** test/testbench.sv ***
// self-checking bench for the strobe timer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, cfg_wr, cfg_rd, req_valid, req_write, req_secondary;
  logic pri_slave_sel, sec_slave_sel, stall, req_ready, done, drv_cs_sec;
  logic drv_rd_n, drv_wr_n, drv_data_oe, drv_ready;
  logic pri_prefetch_en, sec_prefetch_en;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic [3:0] cfg_be;
  logic [2:0] req_index, drv_addr;
  logic [15:0] req_wdata, rd_data, drv_data_in, drv_data_out;
  int error_cnt, check_count, s, a, r, dn;
  int tbl [8] = '{1, 2, 3, 4, 8, 9, 10, 12}; // code to clocks
  ipst_timing uut (.clk(clk), .reset_n(reset_n), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write),
    .req_secondary(req_secondary), .req_index(req_index),
    .req_wdata(req_wdata), .done(done), .rd_data(rd_data),
    .pri_slave_sel(pri_slave_sel), .sec_slave_sel(sec_slave_sel),
    .pri_prefetch_en(pri_prefetch_en), .sec_prefetch_en(sec_prefetch_en),
    .drv_addr(drv_addr), .drv_cs_sec(drv_cs_sec), .drv_rd_n(drv_rd_n),
    .drv_wr_n(drv_wr_n), .drv_data_in(drv_data_in),
    .drv_data_out(drv_data_out), .drv_data_oe(drv_data_oe),
    .drv_ready(drv_ready));
  ipst_drive_model u_drv (.clk(clk), .drv_addr(drv_addr),
    .drv_rd_n(drv_rd_n), .drv_wr_n(drv_wr_n), .drv_data_out(drv_data_out),
    .drv_data_oe(drv_data_oe), .stall(stall), .drv_data_in(drv_data_in),
    .drv_ready(drv_ready));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one register word, all bytes enabled
  task automatic cfg_write(input logic [7:0] ad, input logic [31:0] wd);
    @(negedge clk);
    cfg_wr = 1;
    cfg_addr = ad;
    cfg_wdata = wd;
    @(negedge clk);
    cfg_wr = 0;
  endtask
  task automatic cfg_read(input logic [7:0] ad, output logic [31:0] d);
    @(negedge clk);
    cfg_rd = 1;
    cfg_addr = ad;
    @(negedge clk);
    cfg_rd = 0;
    @(negedge clk);
    d = cfg_rdata;
  endtask
  // one drive cycle; counts setup, active, recovery and the done slot
  task automatic op(input logic w, sc, input logic [2:0] ix,
      input logic [15:0] wd);
    @(negedge clk);
    {req_valid, req_write, req_secondary, req_index, req_wdata} =
      {1'b1, w, sc, ix, wd};
    @(negedge clk);
    req_valid = 0;
    {s, a, r, dn} = '0;
    for (int k = 1; k < 80; k++) begin
      if (done && dn == 0) dn = k;
      if (!(drv_rd_n & drv_wr_n)) a++;
      else if (a == 0) s++;
      else if (req_ready === 1'b1) break;
      else r++;
      @(negedge clk);
    end
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end
  initial begin
    {cfg_wr, cfg_rd, req_valid, req_write, req_secondary} = '0;
    {pri_slave_sel, sec_slave_sel, stall} = '0;
    {cfg_addr, cfg_wdata, req_index, req_wdata} = '0;
    cfg_be = 4'hF;
    reset_n = 0;
    repeat (5) @(negedge clk);
    reset_n = 1;
    cfg_read(8'h40, rd);
    chk("pri reset", rd & 32'h03FF03FF, 32'h97609760 & 32'h03FF03FF);
    cfg_read(8'h44, rd);
    chk("sec reset", rd & 32'h03FF03FF, 32'h97609760 & 32'h03FF03FF);
    cfg_read(8'h48, rd);
    chk("unmapped", rd, 32'h0);
    cfg_write(8'h44, 32'hFFFFFFFF);
    cfg_read(8'h44, rd);
    chk("reserved", rd, 32'h03FF03FF);
    // every recovery and active code on the primary master
    for (int c = 0; c < 8; c++) begin
      cfg_write(8'h40, {16'h9760, 6'h00, 3'(c), 3'(c), 4'h0});
      op(0, 0, 3'h0, 16'h0);
      chk("setup", s, c > 3 ? 3 : c > 1 ? 2 : 1);
      chk("active", a, tbl[c]);
      chk("recovery", r, tbl[c]);
      chk("rd data", rd_data, 16'h5A00);
    end
    cfg_write(8'h40, 32'h97600000);
    op(0, 0, 3'h1, 16'h0);
    chk("ctrl active", a, 10);
    chk("ctrl recovery", r, 10);
    cfg_write(8'h40, 32'h97600004);
    op(1, 0, 3'h0, 16'hBEEF);
    chk("posted done", dn, 1);
    chk("posted data", u_drv.mem[0], 16'hBEEF);
    op(1, 0, 3'h2, 16'h1234);
    chk("ctrl done", dn, s + 11);
    // drive holds ready low, then lets go mid-strobe
    stall = 1; // early enough to pass the ready synchroniser
    cfg_write(8'h40, 32'h97600008);
    fork
      op(0, 0, 3'h0, 16'h0);
      begin
        repeat (6) @(negedge clk);
        stall = 0;
      end
    join
    chk("stretched", a > 3, 1);
    cfg_write(8'h40, 32'h97600000);
    stall = 1;
    op(0, 0, 3'h0, 16'h0);
    stall = 0;
    chk("unstretched", a, 1);
    cfg_write(8'h44, 32'h00100070);
    sec_slave_sel = 1;
    op(0, 1, 3'h0, 16'h0);
    chk("sec slave", a, 2);
    chk("sec port", drv_cs_sec, 1);
    sec_slave_sel = 0;
    op(0, 1, 3'h0, 16'h0);
    chk("sec master", a, 12);
    pri_slave_sel = 1;
    op(0, 0, 3'h0, 16'h0);
    chk("pri slave", a, 10);
    chk("pri port", drv_cs_sec, 0);
    pri_slave_sel = 0;
    // prefetch codes with and without a packet command
    for (int p = 0; p < 2; p++) begin
      op(1, 0, 3'h7, p ? 16'h00A0 : 16'h0020);
      for (int f = 0; f < 4; f++) begin
        cfg_write(8'h40, {30'h25D80000, 2'(f)});
        chk("pref", pri_prefetch_en, f[1] & (f[0] | !p));
      end
    end
    chk("sec prefetch", sec_prefetch_en, 0);
    sec_slave_sel = 1;
    cfg_write(8'h44, 32'h00020000);
    chk("sec pref on", sec_prefetch_en, 1);
    wrap_up;
  end
endmodule
